// file: pkg/pbpac_pkg.sv
package pbpac_pkg;

  // ---------------------------------------------------------------
  // boot mode pin encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] BOOT_NOR  = 3'h0;
  localparam logic [2:0] BOOT_NAND = 3'h1;
  localparam logic [2:0] BOOT_QSPI = 3'h2;
  localparam logic [2:0] BOOT_SD   = 3'h3;
  localparam logic [2:0] BOOT_JTAG = 3'h4;

  // ---------------------------------------------------------------
  // boot controller states, gray along the normal path
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BST_SAMPLE = 3'h0,  // catch mode pins
    BST_INIT   = 3'h1,  // rom code, default controller settings
    BST_HDR    = 3'h3,  // wait for boot image header
    BST_COPY   = 3'h2,  // copy loader into on-chip ram
    BST_BRANCH = 3'h6,  // hand over to the loader
    BST_DONE   = 3'h7,  // rom locked away
    BST_FAIL   = 3'h5   // boot refused
  } pbpac_boot_st_t;

  // ---------------------------------------------------------------
  // default controller settings used until the header overrides them
  // ---------------------------------------------------------------
  localparam logic [15:0] SMC_CFG_RST  = 16'h0000;
  localparam logic [15:0] SDIO_CFG_RST = 16'h0000;

  // ---------------------------------------------------------------
  // clock domains and divider limits
  // ---------------------------------------------------------------
  localparam logic [1:0] DOM_CPU = 2'h0;
  localparam logic [1:0] DOM_DDR = 2'h1;
  localparam logic [1:0] DOM_IO  = 2'h2;
  localparam logic [7:0] DIV_RST = 8'h02;
  localparam int unsigned PLL_MHZ     = 1332;  // pll output rate
  localparam int unsigned CPU_MIN_MHZ = 30;    // slowest cpu clock
  localparam logic [7:0] CPU_DIV_MAX  = 8'(PLL_MHZ / CPU_MIN_MHZ);

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [31:0] MAP_DDR_BASE  = 32'h0000_0000;
  localparam logic [31:0] MAP_DDR_SIZE  = 32'h4000_0000;
  localparam logic [31:0] MAP_AXI0_BASE = 32'h4000_0000;
  localparam logic [31:0] MAP_AXI0_SIZE = 32'h4000_0000;
  localparam logic [31:0] MAP_AXI1_BASE = 32'h8000_0000;
  localparam logic [31:0] MAP_AXI1_SIZE = 32'h4000_0000;
  localparam logic [31:0] MAP_IOP_BASE  = 32'hE000_0000;
  localparam logic [31:0] MAP_IOP_SIZE  = 32'h1000_0000;
  localparam logic [31:0] MAP_APB_BASE  = 32'hF800_0000;
  localparam logic [31:0] MAP_APB_SIZE  = 32'h0200_0000;
  localparam logic [31:0] MAP_QSPI_BASE = 32'hFC00_0000;
  localparam logic [31:0] MAP_QSPI_SIZE = 32'h0200_0000;
  localparam logic [31:0] MAP_OCMH_BASE = 32'hFFFC_0000;
  localparam logic [31:0] MAP_OCMH_SIZE = 32'h0004_0000;

  // decoder target codes
  localparam logic [2:0] TGT_NONE  = 3'h0;
  localparam logic [2:0] TGT_DDR   = 3'h1;
  localparam logic [2:0] TGT_AXI0  = 3'h2;
  localparam logic [2:0] TGT_AXI1  = 3'h3;
  localparam logic [2:0] TGT_IOP   = 3'h4;
  localparam logic [2:0] TGT_APB   = 3'h5;
  localparam logic [2:0] TGT_QSPI  = 3'h6;
  localparam logic [2:0] TGT_OCMH  = 3'h7;

endpackage

// file: src/pbpac_addr_dec.sv
module pbpac_addr_dec
  import pbpac_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        req_i,      // access request
  input  wire logic [31:0] addr_i,     // byte address
  input  wire logic        ocm_high_i, // on-chip ram mapped high
  output logic             fwd_o,      // access forwarded
  output logic [2:0]       tgt_o,      // selected target code
  output logic             err_o       // bus error answer
);

  // ---------------------------------------------------------------
  // range test, used for every region
  // ---------------------------------------------------------------
  function automatic logic in_rng(input logic [31:0] a,
                                  input logic [31:0] base,
                                  input logic [31:0] size);
    logic [31:0] off;
    off    = a - base;
    in_rng = (a >= base) && (off < size);
  endfunction

  logic [2:0] tgt_nxt; // combinational target

  // ---------------------------------------------------------------
  // region select, holes fall through to no target
  // ---------------------------------------------------------------
  always_comb begin
    tgt_nxt = TGT_NONE;
    if (in_rng(addr_i, MAP_DDR_BASE, MAP_DDR_SIZE)) begin
      tgt_nxt = TGT_DDR;
    end else if (in_rng(addr_i, MAP_AXI0_BASE, MAP_AXI0_SIZE)) begin
      tgt_nxt = TGT_AXI0;
    end else if (in_rng(addr_i, MAP_AXI1_BASE, MAP_AXI1_SIZE)) begin
      tgt_nxt = TGT_AXI1;
    end else if (in_rng(addr_i, MAP_IOP_BASE, MAP_IOP_SIZE)) begin
      tgt_nxt = TGT_IOP;
    end else if (in_rng(addr_i, MAP_APB_BASE, MAP_APB_SIZE)) begin
      tgt_nxt = TGT_APB;
    end else if (in_rng(addr_i, MAP_QSPI_BASE, MAP_QSPI_SIZE)) begin
      tgt_nxt = TGT_QSPI;
    end else if (ocm_high_i && in_rng(addr_i, MAP_OCMH_BASE, MAP_OCMH_SIZE)) begin
      tgt_nxt = TGT_OCMH;
    end
  end

  // ---------------------------------------------------------------
  // registered answer, one cycle after the request
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fwd_o <= 1'b0;
      tgt_o <= TGT_NONE;
      err_o <= 1'b0;
    end else begin
      // reserved holes never reach a target
      fwd_o <= req_i && (tgt_nxt != TGT_NONE);
      tgt_o <= req_i ? tgt_nxt : TGT_NONE;
      err_o <= req_i && (tgt_nxt == TGT_NONE);
    end
  end

endmodule

// file: src/pbpac_top.sv
// Function
// - three pll domains, independently set by software
// - sample mode pins, pick boot source
// - jtag boot is never secure
// - secure boot needs fabric power on
// - rom runs, copies loader, then branches
// - default controller settings, header may override
// - rom blocked after boot completes
// - chained jtag: one port reaches all
// - split jtag: dap port, fabric port
// - system power off holds fabric reset
// - fabric unconfigured after every power on
// - cpu clock not below 30 mhz
// - clock writes rejected while space locked
// - single cpu mode gates second cpu
// - low 1 gb to dram and ram
// - second gb to fabric axi port 0
// - third gb to fabric axi port 1
// - peripherals, reserved hole, apb registers
// - quad spi window, 32 mb supported
// - high on-chip ram when mapped high
module pbpac_top
  import pbpac_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // boot
  input  wire logic [2:0]  boot_mode_i,       // mode pins
  input  wire logic        hdr_valid_i,       // boot image header read
  input  wire logic        hdr_secure_i,      // header asks for secure boot
  input  wire logic        hdr_ovr_i,         // header carries settings
  input  wire logic [15:0] hdr_smc_cfg_i,     // static memory settings
  input  wire logic [15:0] hdr_sdio_cfg_i,    // sdio settings
  input  wire logic        copy_done_i,       // loader now in on-chip ram
  input  wire logic        rom_acc_i,         // read or call into rom
  output logic [2:0]       boot_src_o,        // held boot source
  output logic             rom_run_o,         // cpu0 runs rom code
  output logic             copy_req_o,        // copy loader request
  output logic             branch_o,          // one-cycle branch to loader
  output logic             boot_done_o,       // boot complete
  output logic             boot_err_o,        // boot refused
  output logic             secure_o,          // secure boot taken, held after boot completes
  output logic [15:0]      smc_cfg_o,         // static memory settings
  output logic [15:0]      sdio_cfg_o,        // sdio settings
  output logic             rom_grant_o,       // rom access allowed
  output logic             rom_deny_o,        // rom access blocked
  // debug ports
  input  wire logic        jtag_chain_i,      // 1 chained, 0 split
  output logic             jtag0_dap_o,       // port 0 to debug_access_port
  output logic             jtag0_fabric_o,    // port 0 to fabric tap
  output logic             jtag1_fabric_o,    // port 1 to fabric tap
  // power
  input  wire logic        ps_pwr_off_i,      // processing_system power off
  input  wire logic        fabric_pwr_req_i,  // software asks for fabric power
  input  wire logic        fabric_pwr_good_i, // fabric rail up
  input  wire logic        fabric_cfg_done_i, // configuration finished
  output logic             fabric_pwr_en_o,   // to external power circuitry
  output logic             fabric_rst_n_o,    // fabric reset, active low
  output logic             fabric_cfg_ok_o,   // fabric configured
  // clocks
  input  wire logic        scr_unlock_i,      // control space unlocked
  input  wire logic        clk_wr_i,          // clock register write
  input  wire logic [1:0]  clk_wr_dom_i,      // domain to write
  input  wire logic [7:0]  clk_wr_div_i,      // new divider
  input  wire logic        single_cpu_i,      // single processor mode
  output logic [7:0]       cpu_div_o,         // application cpu divider
  output logic [7:0]       ddr_div_o,         // ddr divider
  output logic [7:0]       io_div_o,          // io_peripheral_group divider
  output logic             clk_wr_rej_o,      // one-cycle reject pulse
  output logic             cpu0_clk_en_o,     // first cpu clock enable
  output logic             cpu1_clk_en_o,     // second cpu clock enable
  // address decode
  input  wire logic        bus_req_i,         // access request
  input  wire logic [31:0] bus_addr_i,        // byte address
  input  wire logic        ocm_high_i,        // on_chip_ram mapped high
  output logic             bus_fwd_o,         // forwarded to target
  output logic [2:0]       bus_tgt_o,         // target code
  output logic             bus_err_o          // bus error answer
);

  // ---------------------------------------------------------------
  // boot mode capture
  // ---------------------------------------------------------------
  logic           mode_taken_r; // pins already caught
  pbpac_boot_st_t bst_r;        // boot state
  pbpac_boot_st_t bst_nxt;      // next boot state

  // caught once after reset release, not in reset: a strap is a port
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_taken_r <= 1'b0;
      boot_src_o   <= BOOT_NOR;
    end else if (!mode_taken_r) begin
      mode_taken_r <= 1'b1;
      boot_src_o   <= boot_mode_i;
    end
    // later pin changes are ignored until next reset
  end

  // ---------------------------------------------------------------
  // secure boot admission
  // ---------------------------------------------------------------
  logic sec_ok; // secure boot may proceed
  // jtag source and unpowered fabric both block secure boot
  assign sec_ok = (boot_src_o != BOOT_JTAG)
                && fabric_pwr_good_i
                && !ps_pwr_off_i;

  // ---------------------------------------------------------------
  // boot sequence next state
  // ---------------------------------------------------------------
  always_comb begin
    bst_nxt = bst_r;
    case (bst_r)
      BST_SAMPLE: begin
        bst_nxt = BST_INIT;
      end
      BST_INIT: begin
        bst_nxt = BST_HDR;
      end
      BST_HDR: begin
        if (hdr_valid_i) begin
          if (hdr_secure_i && !sec_ok) begin
            bst_nxt = BST_FAIL;
          end else begin
            bst_nxt = BST_COPY;
          end
        end
      end
      BST_COPY: begin
        // secure path stays gated by fabric power during the copy
        if (secure_o && !sec_ok) begin
          bst_nxt = BST_FAIL;
        end else if (copy_done_i) begin
          bst_nxt = BST_BRANCH;
        end
      end
      BST_BRANCH: begin
        bst_nxt = BST_DONE;
      end
      BST_DONE: begin
        bst_nxt = BST_DONE;
      end
      BST_FAIL: begin
        bst_nxt = BST_FAIL;
      end
      default: begin
        bst_nxt = BST_FAIL;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bst_r <= BST_SAMPLE;
    end else begin
      bst_r <= bst_nxt;
    end
  end

  // ---------------------------------------------------------------
  // boot outputs, all registered from the next state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rom_run_o   <= 1'b0;
      copy_req_o  <= 1'b0;
      branch_o    <= 1'b0;
      boot_done_o <= 1'b0;
      boot_err_o  <= 1'b0;
    end else begin
      // one cpu runs rom code until the branch
      rom_run_o   <= (bst_nxt == BST_INIT) || (bst_nxt == BST_HDR)
                   || (bst_nxt == BST_COPY);
      copy_req_o  <= (bst_nxt == BST_COPY);
      branch_o    <= (bst_nxt == BST_BRANCH);
      boot_done_o <= (bst_nxt == BST_DONE);
      boot_err_o  <= (bst_nxt == BST_FAIL);
    end
  end

  // secure flag latched with the header
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      secure_o <= 1'b0;
    end else if (bst_r == BST_HDR && bst_nxt == BST_COPY) begin
      secure_o <= hdr_secure_i;
    end else if (bst_nxt == BST_FAIL) begin
      secure_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // controller settings: defaults, then header override
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      smc_cfg_o  <= SMC_CFG_RST;
      sdio_cfg_o <= SDIO_CFG_RST;
    end else if (bst_r == BST_INIT) begin
      // defaults are slow but safe for any boot part
      smc_cfg_o  <= SMC_CFG_RST;
      sdio_cfg_o <= SDIO_CFG_RST;
    end else if (bst_r == BST_HDR && hdr_valid_i && hdr_ovr_i) begin
      smc_cfg_o  <= hdr_smc_cfg_i;
      sdio_cfg_o <= hdr_sdio_cfg_i;
    end
  end

  // ---------------------------------------------------------------
  // rom access guard
  // ---------------------------------------------------------------
  logic rom_locked; // boot has left rom for good
  // a failed boot also locks, so a refused image cannot reuse rom code
  assign rom_locked = (bst_r == BST_DONE) || (bst_r == BST_FAIL)
                    || (bst_r == BST_BRANCH);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rom_grant_o <= 1'b0;
      rom_deny_o  <= 1'b0;
    end else begin
      rom_grant_o <= rom_acc_i && !rom_locked;
      rom_deny_o  <= rom_acc_i && rom_locked;
    end
  end

  // ---------------------------------------------------------------
  // jtag routing
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      jtag0_dap_o    <= 1'b1;
      jtag0_fabric_o <= 1'b1;
      jtag1_fabric_o <= 1'b0;
    end else if (jtag_chain_i) begin
      // one cable reaches cpu debug and the fabric tap
      jtag0_dap_o    <= 1'b1;
      jtag0_fabric_o <= 1'b1;
      jtag1_fabric_o <= 1'b0;
    end else begin
      // split: port 1 sees only the fabric, like a lone fpga
      jtag0_dap_o    <= 1'b1;
      jtag0_fabric_o <= 1'b0;
      jtag1_fabric_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // fabric power and reset
  // ---------------------------------------------------------------
  logic pwr_good_d_r; // last rail state, for power-on edge

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fabric_pwr_en_o <= 1'b0;
      fabric_rst_n_o  <= 1'b0;
    end else begin
      // request only honoured while the system itself is up
      fabric_pwr_en_o <= fabric_pwr_req_i && !ps_pwr_off_i;
      // reset held whenever system is off or rail is down
      fabric_rst_n_o  <= !ps_pwr_off_i && fabric_pwr_good_i;
    end
  end

  // configured flag: lost on each power cycle; power-on wins over done
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_good_d_r    <= 1'b0;
      fabric_cfg_ok_o <= 1'b0;
    end else begin
      pwr_good_d_r <= fabric_pwr_good_i;
      if (!fabric_pwr_good_i || ps_pwr_off_i
          || (fabric_pwr_good_i && !pwr_good_d_r)) begin
        fabric_cfg_ok_o <= 1'b0;
      end else if (fabric_cfg_done_i) begin
        fabric_cfg_ok_o <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // clock dividers behind the lock
  // ---------------------------------------------------------------
  logic clk_wr_ok; // write accepted this cycle
  // zero divider is meaningless; cpu divider capped to stay >= 30 mhz
  assign clk_wr_ok = scr_unlock_i
                   && (clk_wr_div_i != 8'h00)
                   && (clk_wr_dom_i != 2'h3)
                   && !((clk_wr_dom_i == DOM_CPU)
                        && (clk_wr_div_i > CPU_DIV_MAX));

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_div_o    <= DIV_RST;
      ddr_div_o    <= DIV_RST;
      io_div_o     <= DIV_RST;
      clk_wr_rej_o <= 1'b0;
    end else begin
      clk_wr_rej_o <= clk_wr_i && !clk_wr_ok;
      if (clk_wr_i && clk_wr_ok) begin
        // each domain has its own divider
        case (clk_wr_dom_i)
          DOM_CPU: cpu_div_o <= clk_wr_div_i;
          DOM_DDR: ddr_div_o <= clk_wr_div_i;
          DOM_IO:  io_div_o  <= clk_wr_div_i;
          default: cpu_div_o <= cpu_div_o;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // cpu clock gating
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu0_clk_en_o <= 1'b1;
      cpu1_clk_en_o <= 1'b0;
    end else begin
      cpu0_clk_en_o <= 1'b1;
      // second cpu idles through rom boot; only first runs rom
      cpu1_clk_en_o <= !single_cpu_i && rom_locked;
    end
  end

  // ---------------------------------------------------------------
  // address decoder
  // ---------------------------------------------------------------
  pbpac_addr_dec u_dec (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .req_i      (bus_req_i),
    .addr_i     (bus_addr_i),
    .ocm_high_i (ocm_high_i),
    .fwd_o      (bus_fwd_o),
    .tgt_o      (bus_tgt_o),
    .err_o      (bus_err_o)
  );

endmodule

// file: testbench/pbpac_top_props.sv
module pbpac_top_props
  import pbpac_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        jtag_chain_i,
  input wire logic        jtag0_dap_o,
  input wire logic        jtag0_fabric_o,
  input wire logic        jtag1_fabric_o,
  input wire logic        ps_pwr_off_i,
  input wire logic        fabric_rst_n_o,
  input wire logic        fabric_pwr_en_o,
  input wire logic        boot_done_o,
  input wire logic        rom_acc_i,
  input wire logic        rom_deny_o,
  input wire logic        clk_wr_i,
  input wire logic        scr_unlock_i,
  input wire logic        clk_wr_rej_o,
  input wire logic [7:0]  cpu_div_o,
  input wire logic        single_cpu_i,
  input wire logic        cpu1_clk_en_o,
  input wire logic [2:0]  boot_src_o,
  input wire logic        bus_req_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic        bus_fwd_o,
  input wire logic [2:0]  bus_tgt_o,
  input wire logic        bus_err_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ------------------------------------------------------------
  // one cycle from cause to registered answer
  // ------------------------------------------------------------
  jtag_split_a: assert property (
    !jtag_chain_i |=> jtag0_dap_o && !jtag0_fabric_o && jtag1_fabric_o) else $error("split route");
  fabric_hold_a: assert property (
    ps_pwr_off_i |=> !fabric_rst_n_o && !fabric_pwr_en_o) else $error("fabric not held");
  rom_lock_a: assert property (
    boot_done_o && rom_acc_i |=> rom_deny_o) else $error("rom open after boot");
  locked_write_a: assert property (
    clk_wr_i && !scr_unlock_i |=> clk_wr_rej_o && $stable(cpu_div_o)) else $error("locked write");
  cpu_gate_a: assert property (
    single_cpu_i |=> !cpu1_clk_en_o) else $error("second cpu clocked");
  mode_hold_a: assert property (
    boot_done_o |=> $stable(boot_src_o)) else $error("boot source moved");
  axi0_route_a: assert property (
    bus_req_i && bus_addr_i[31:30] == 2'h1 |=> bus_fwd_o && bus_tgt_o == TGT_AXI0)
      else $error("axi0");
  hole_error_a: assert property (
    bus_req_i && bus_addr_i[31:27] == 5'h1E |=> bus_err_o && !bus_fwd_o) else $error("hole fwd");
endmodule
bind pbpac_top pbpac_top_props u_props (.*);

// file: testbench/pbpac_partner.sv
module pbpac_partner (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic slow_i,      // stretch header and copy delays
  input  wire logic rom_run_i,
  input  wire logic copy_req_i,
  input  wire logic pwr_en_i,
  input  wire logic ps_off_i,
  output logic      hdr_valid_o, // one-cycle header pulse
  output logic      copy_done_o,
  output logic      pwr_good_o   // fabric rail state
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // boot memory and external power circuitry
  // ------------------------------------------------------------
  logic [4:0] cnt_r;             // cycles since rom code started
  logic [4:0] dly;
  assign dly = slow_i ? 5'h08 : 5'h03;
  // counter saturates so a stuck boot never wraps into a fake header
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) cnt_r <= 5'h00;
    else if (!rom_run_i) cnt_r <= 5'h00;
    else if (cnt_r != 5'h1F) cnt_r <= cnt_r + 5'h01;
  end
  assign hdr_valid_o = (cnt_r == dly);
  assign copy_done_o = copy_req_i && (cnt_r > (dly << 1));
  // rail never comes up while the processing system is off
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) pwr_good_o <= 1'b0;
    else pwr_good_o <= pwr_en_i && !ps_off_i;
  end
endmodule

// file: testbench/pbpac_top_bench.sv
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, s); end end
module pbpac_top_bench
  import pbpac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // design ports and bench state
  // ------------------------------------------------------------
  logic core_clk_i = 1'b0, nrst_i = 1'b0, hdr_valid_i, copy_done_i, fabric_pwr_good_i;
  logic [2:0] boot_mode_i = 3'h0, boot_src_o, bus_tgt_o, t;
  logic hdr_secure_i = 1'b0, hdr_ovr_i = 1'b0, rom_acc_i = 1'b0, jtag_chain_i = 1'b1;
  logic [15:0] hdr_smc_cfg_i = 16'h0000, hdr_sdio_cfg_i = 16'h0000, smc_cfg_o, sdio_cfg_o;
  logic rom_run_o, copy_req_o, branch_o, boot_done_o, boot_err_o, secure_o, rom_grant_o;
  logic rom_deny_o, jtag0_dap_o, jtag0_fabric_o, jtag1_fabric_o, fabric_pwr_en_o;
  logic ps_pwr_off_i = 1'b0, fabric_pwr_req_i = 1'b0, fabric_cfg_done_i = 1'b0;
  logic fabric_rst_n_o, fabric_cfg_ok_o, scr_unlock_i = 1'b0, clk_wr_i = 1'b0, slow = 1'b0;
  logic [1:0] clk_wr_dom_i = 2'h0;
  logic [7:0] clk_wr_div_i = 8'h00, cpu_div_o, ddr_div_o, io_div_o, dv [4];
  logic clk_wr_rej_o, cpu0_clk_en_o, cpu1_clk_en_o, single_cpu_i = 1'b0, bus_req_i = 1'b0;
  logic ocm_high_i = 1'b0, bus_fwd_o, bus_err_o, ok;
  logic [31:0] bus_addr_i = 32'h0000_0000, a;
  logic [10:0] w;                // {unlock, domain, divider}
  int checks = 0, n_errors = 0, i;
  logic [10:0] cw [5] = '{11'h008, 11'h42C, 11'h42D, 11'h705, 11'h500};
  logic [31:0] ca [12] = '{32'h0000_0000, 32'h3FFF_FFFF, 32'h4000_0000, 32'hBFFF_FFFF,
    32'hC000_0000, 32'hE000_0000, 32'hF000_0000, 32'hF800_0000, 32'hFA00_0000,
    32'hFC00_0000, 32'hFE00_0000, 32'hFFFC_0000};
  pbpac_top dut (.*);
  pbpac_partner u_far (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .slow_i(slow),
    .rom_run_i(rom_run_o), .copy_req_i(copy_req_o), .pwr_en_i(fabric_pwr_en_o),
    .ps_off_i(ps_pwr_off_i), .hdr_valid_o(hdr_valid_i), .copy_done_o(copy_done_i),
    .pwr_good_o(fabric_pwr_good_i));
  always #2.5 core_clk_i = ~core_clk_i;
  task automatic go(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // expected target of an access; unmapped holes give none
  function automatic logic [2:0] exp_tgt(logic [31:0] x, logic hi);
    if (x[31:30] != 2'h3) return 3'(x[31:30]) + 3'h1;
    if (x[31:28] == 4'hE) return TGT_IOP;
    if (x[31:25] == 7'h7C) return TGT_APB;
    if (x[31:25] == 7'h7E) return TGT_QSPI;
    if (hi && x[31:18] == 14'h3FFF) return TGT_OCMH;
    return TGT_NONE;
  endfunction
  function automatic logic wr_ok(logic [10:0] v);
    return v[10] && v[7:0] != 8'h00 && v[9:8] != 2'h3 &&
      !(v[9:8] == DOM_CPU && v[7:0] > CPU_DIV_MAX);
  endfunction
  task automatic complete_run;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // one full boot from reset, then rom lock and mode hold
  // ------------------------------------------------------------
  task automatic boot(logic [2:0] m, logic s, logic p);
    logic bad;
    logic [15:0] h;
    h = 16'($urandom);
    bad = s && (m == BOOT_JTAG || !p);
    go(1);
    nrst_i <= 1'b0;
    boot_mode_i <= m;
    hdr_secure_i <= s;
    fabric_pwr_req_i <= p;
    hdr_ovr_i <= h[0];
    hdr_smc_cfg_i <= h;
    hdr_sdio_cfg_i <= ~h;
    slow <= h[1];
    go(2);
    nrst_i <= 1'b1;
    for (int k = 0; k < 80 && boot_done_o !== 1'b1 && boot_err_o !== 1'b1; k++) go(1);
    #1;
    `CHK("boot_src", m, boot_src_o)
    `CHK("boot_err", bad, boot_err_o)
    `CHK("boot_done", !bad, boot_done_o)
    `CHK("seq", {3'h0, s & !bad}, {rom_run_o, copy_req_o, branch_o, secure_o})
    if (!bad)
      `CHK("cfg", h[0] ? {h, ~h} : {SMC_CFG_RST, SDIO_CFG_RST}, {smc_cfg_o, sdio_cfg_o})
    go(1);
    rom_acc_i <= 1'b1;
    boot_mode_i <= ~m;
    go(1);
    rom_acc_i <= 1'b0;
    #1;
    `CHK("rom", 2'b01, {rom_grant_o, rom_deny_o})
    go(2);
    #1;
    `CHK("src_held", m, boot_src_o)
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h1C57));
    go(2);
    #1;
    `CHK("rst", {cpu_div_o, io_div_o, jtag0_dap_o, fabric_rst_n_o}, {{2{DIV_RST}}, 2'b10})
    for (i = 0; i < 10; i++) boot(3'(i / 2), i[0], 1'($urandom));
    boot(BOOT_NOR, 1'b1, 1'b0);
    boot(BOOT_SD, 1'b0, 1'b1);
    for (i = 0; i < 2; i++) begin
      go(1);
      jtag_chain_i <= i[0];
      single_cpu_i <= !i[0];
      go(2);
      #1;
      `CHK("jtag", i[0] ? 3'b110 : 3'b101, {jtag0_dap_o, jtag0_fabric_o, jtag1_fabric_o})
      `CHK("cpu_clk", {1'b1, i[0]}, {cpu0_clk_en_o, cpu1_clk_en_o})
    end
    go(1);
    ps_pwr_off_i <= 1'b1;
    go(3);
    #1;
    `CHK("pl_hold", 2'b00, {fabric_rst_n_o, fabric_pwr_en_o})
    go(1);
    ps_pwr_off_i <= 1'b0;
    fabric_cfg_done_i <= 1'b1;
    go(5);
    #1;
    `CHK("pl_up", 2'b11, {fabric_rst_n_o, fabric_cfg_ok_o})
    go(1);
    fabric_cfg_done_i <= 1'b0;
    fabric_pwr_req_i <= 1'b0;
    go(3);
    fabric_pwr_req_i <= 1'b1;
    go(4);
    #1;
    `CHK("pl_cfg", 1'b0, fabric_cfg_ok_o)
    dv = '{DIV_RST, DIV_RST, DIV_RST, DIV_RST};
    for (i = 0; i < 40; i++) begin
      w = (i < 5) ? cw[i] : 11'($urandom);
      if (i >= 5) w[10] = ($urandom % 4) != 0;
      if (i >= 5) w[7:6] = 2'h0;
      ok = wr_ok(w);
      if (ok) dv[w[9:8]] = w[7:0];
      go(1);
      {scr_unlock_i, clk_wr_dom_i, clk_wr_div_i} <= w;
      clk_wr_i <= 1'b1;
      go(1);
      clk_wr_i <= 1'b0;
      #1;
      `CHK("clk_rej", !ok, clk_wr_rej_o)
      `CHK("divs", {dv[0], dv[1], dv[2]}, {cpu_div_o, ddr_div_o, io_div_o})
    end
    for (i = 0; i < 60; i++) begin
      a = (i < 12) ? ca[i] : $urandom;
      if (i >= 12 && i[0]) a[31:28] = 4'hF;
      ok = 1'($urandom);
      t = exp_tgt(a, ok);
      go(1);
      bus_req_i <= 1'b1;
      bus_addr_i <= a;
      ocm_high_i <= ok;
      go(1);
      bus_req_i <= 1'b0;
      #1;
      `CHK("dec", {t != 3'h0, t == 3'h0, t}, {bus_fwd_o, bus_err_o, bus_tgt_o})
    end
    complete_run();
  end
endmodule
